// ---- rtl/pss_pkg.sv ----
// Shared constants and types of the program sequencer with return stack.
package pss_pkg;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  // The larger variant has a 13-bit counter; the smaller uses bits 11 to 0.
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [SP_W:0] STACK_EMPTY = 4'h0;
  localparam logic [SP_W:0] STACK_FULL = 4'h8;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic INT_EN_RESET = 1'b1;

  // ==========================================================================
  // Instruction cycle phases
  // ==========================================================================
  typedef enum logic [3:0] {
    PH_FETCH = 4'h1,
    PH_DECODE = 4'h2,
    PH_EXECUTE = 4'h4,
    PH_WRITE = 4'h8
  } pss_phase_type;

  // ==========================================================================
  // Instruction encoding
  // ==========================================================================
  typedef enum logic [2:0] {
    OPC_ALU = 3'h0,
    OPC_JUMP = 3'h1,
    OPC_CALL = 3'h2,
    OPC_RETURN = 3'h3,
    OPC_LOW_WR = 3'h4,
    OPC_LONG = 3'h5,
    OPC_LOW_RD = 3'h6,
    OPC_NOP = 3'h7
  } pss_opc_type;

  typedef enum logic [4:0] {
    F_ADD = 5'h00, F_ADC = 5'h01, F_SUB = 5'h02, F_SBC = 5'h03,
    F_DAA = 5'h04, F_AND = 5'h05, F_OR = 5'h06, F_XOR = 5'h07,
    F_CPL = 5'h08, F_RR = 5'h09, F_RRC = 5'h0A, F_RL = 5'h0B,
    F_RLC = 5'h0C, F_INC = 5'h0D, F_DEC = 5'h0E, F_SZ = 5'h0F,
    F_SNZ = 5'h10, F_SIZ = 5'h11, F_SDZ = 5'h12, F_MOV = 5'h13
  } pss_func_type;

  localparam logic [4:0] SUB_RETURN = 5'h00;
  localparam logic [4:0] SUB_INT_RETURN = 5'h01;

  typedef struct packed {
    pss_opc_type opc;
    logic [4:0] func;
    logic [7:0] imm;
  } pss_instr_type;

  localparam pss_instr_type INSTR_RESET = 16'hE000;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } pss_status_type;

  localparam pss_status_type STATUS_RESET = 4'h0;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    pss_status_type status;
    logic skip;
  } pss_alu_out_type;

endpackage : pss_pkg

// ---- rtl/pss_stack.sv ----
// Eight-level return stack of program counter values.
`timescale 1ns/10ps
module pss_stack import pss_pkg::*; (
  // Clock, reset and enable.
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Push and pop.
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [PC_W-1:0] data_i,
  // State.
  output logic [PC_W-1:0] top_o,
  output logic full_o
);

  logic [PC_W-1:0] mem [STACK_DEPTH];
  logic [SP_W-1:0] ptr;
  logic [SP_W:0] count;

  // ==========================================================================
  // Pointer and fill level
  // ==========================================================================
  // The pointer wraps, so a push into a full stack loses the oldest entry.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ptr <= SP_RESET;
      count <= STACK_EMPTY;
    end else if (ce_i) begin
      if (push_i) begin
        ptr <= ptr + 3'h1;
        if (count != STACK_FULL) begin
          count <= count + 4'h1;
        end
      end else if (pop_i) begin
        ptr <= ptr - 3'h1;
        if (count != STACK_EMPTY) begin
          count <= count - 4'h1;
        end
      end
    end
  end

  // ==========================================================================
  // Storage
  // ==========================================================================
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && push_i) begin
      mem[ptr] <= data_i;
    end
  end

  // The top entry is read a cycle late; pushes and pops are four apart.
  always_ff @(posedge ref_clk_i) begin
    if (ce_i) begin
      top_o <= mem[ptr - 3'h1];
    end
  end

  assign full_o = (count == STACK_FULL);

endmodule : pss_stack

// ---- rtl/pss_alu.sv ----
// Eight-bit arithmetic and logic unit with status and skip decision.
`timescale 1ns/10ps
module pss_alu import pss_pkg::*; (
  // Operands.
  input wire logic [DATA_W-1:0] a_i,
  input wire logic [DATA_W-1:0] b_i,
  input wire logic [4:0] func_i,
  input wire pss_status_type status_i,
  // Result.
  output pss_alu_out_type out_o
);

  // Returns half carry, carry and the eight-bit sum.
  function automatic logic [9:0] add_op(input logic [7:0] x,
                                        input logic [7:0] y,
                                        input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
    return {h[4], s};
  endfunction : add_op

  logic [9:0] s;
  logic [7:0] bop;
  logic [7:0] adj;

  // ==========================================================================
  // Operations
  // ==========================================================================
  // Carry set after a subtraction means no borrow occurred.
  always_comb begin
    out_o.result = a_i;
    out_o.status = status_i;
    out_o.skip = 1'b0;
    bop = 8'h00;
    adj = 8'h00;
    s = 10'h000;
    case (func_i)
      F_ADD, F_ADC, F_SUB, F_SBC: begin
        bop = (func_i == F_SUB || func_i == F_SBC) ? ~b_i : b_i;
        s = add_op(a_i, bop, (func_i == F_SUB) ? 1'b1 :
                   (func_i == F_ADC || func_i == F_SBC) ? status_i.c : 1'b0);
        out_o.result = s[7:0];
        out_o.status.c = s[8];
        out_o.status.ac = s[9];
        out_o.status.ov = (a_i[7] == bop[7]) && (s[7] != a_i[7]);
        out_o.status.z = (s[7:0] == 8'h00);
      end
      F_DAA: begin
        adj[3:0] = (a_i[3:0] > 4'h9 || status_i.ac) ? 4'h6 : 4'h0;
        adj[7:4] = (a_i[7:4] > 4'h9 || status_i.c) ? 4'h6 : 4'h0;
        s = add_op(a_i, adj, 1'b0);
        out_o.result = s[7:0];
        out_o.status.c = s[8] | status_i.c;
      end
      F_AND, F_OR, F_XOR, F_CPL, F_MOV: begin
        case (func_i)
          F_AND: out_o.result = a_i & b_i;
          F_OR: out_o.result = a_i | b_i;
          F_XOR: out_o.result = a_i ^ b_i;
          F_CPL: out_o.result = ~a_i;
          default: out_o.result = b_i;
        endcase
        out_o.status.z = (out_o.result == 8'h00);
      end
      F_RR: out_o.result = {a_i[0], a_i[7:1]};
      F_RL: out_o.result = {a_i[6:0], a_i[7]};
      F_RRC: begin
        out_o.result = {status_i.c, a_i[7:1]};
        out_o.status.c = a_i[0];
      end
      F_RLC: begin
        out_o.result = {a_i[6:0], status_i.c};
        out_o.status.c = a_i[7];
      end
      F_INC, F_DEC, F_SIZ, F_SDZ: begin
        bop = (func_i == F_INC || func_i == F_SIZ) ? 8'h01 : 8'hFF;
        s = add_op(a_i, bop, 1'b0);
        out_o.result = s[7:0];
        if (func_i == F_INC || func_i == F_DEC) begin
          out_o.status.z = (s[7:0] == 8'h00);
        end else begin
          out_o.skip = (s[7:0] == 8'h00);
        end
      end
      F_SZ: out_o.skip = (a_i == 8'h00);
      F_SNZ: out_o.skip = (a_i != 8'h00);
      default: out_o.result = a_i;
    endcase
  end

endmodule : pss_alu

// ---- rtl/pss_sequencer.sv ----
// Four-phase instruction sequencer with prefetch, return stack and ALU.
`timescale 1ns/10ps
module pss_sequencer import pss_pkg::*; (
  // Clock, reset and enable.
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Program memory.
  output logic [PC_W-1:0] pmem_addr_o,
  input wire pss_instr_type pmem_data_i,
  // Interrupt logic.
  input wire logic int_req_i,
  input wire logic [PC_W-1:0] int_vector_i,
  output logic int_ack_o,
  // Observed state.
  output pss_phase_type phase_o,
  output logic [DATA_W-1:0] acc_o,
  output pss_status_type status_o,
  output logic stack_full_o,
  output logic dummy_cycle_o
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  pss_instr_type fetch_word;
  pss_instr_type exec_word;
  pss_alu_out_type alu_out;
  logic long_second;
  logic int_enable;
  logic boundary;
  logic exec_valid;
  logic [PC_W-1:0] target;
  logic [PC_W-1:0] next_pc;
  logic [PC_W-1:0] push_data;
  logic [PC_W-1:0] stack_top;
  logic stack_full;
  logic flush;
  logic hold;
  logic push;
  logic pop;
  logic take_int;
  logic set_int_enable;
  logic write_acc;

  assign boundary = ce_i && (phase_o == PH_WRITE);
  assign exec_valid = !dummy_cycle_o;
  assign target = {exec_word.func, exec_word.imm};

  // ==========================================================================
  // Phase generator
  // ==========================================================================
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      phase_o <= PH_FETCH;
    end else if (ce_i) begin
      case (phase_o)
        PH_FETCH: phase_o <= PH_DECODE;
        PH_DECODE: phase_o <= PH_EXECUTE;
        PH_EXECUTE: phase_o <= PH_WRITE;
        PH_WRITE: phase_o <= PH_FETCH;
        default: phase_o <= PH_FETCH;
      endcase
    end
  end

  // ==========================================================================
  // Fetch stage
  // ==========================================================================
  // The word is taken at the edge that ends the fetch phase.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      fetch_word <= INSTR_RESET;
    end else if (ce_i && phase_o == PH_FETCH) begin
      fetch_word <= pmem_data_i;
    end
  end

  // ==========================================================================
  // Next counter decision
  // ==========================================================================
  // Decided during decode and execute, applied at the cycle boundary.
  always_comb begin
    next_pc = pmem_addr_o + 13'h0001;
    flush = 1'b0;
    hold = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_data = pmem_addr_o;
    take_int = 1'b0;
    set_int_enable = 1'b0;
    write_acc = 1'b0;
    if (exec_valid) begin
      case (exec_word.opc)
        OPC_ALU: begin
          write_acc = 1'b1;
          flush = alu_out.skip;
        end
        OPC_LONG: begin
          if (!long_second) begin
            hold = 1'b1;
          end else begin
            write_acc = 1'b1;
            flush = alu_out.skip;
          end
        end
        OPC_JUMP: begin
          next_pc = target;
          flush = 1'b1;
        end
        OPC_CALL: begin
          next_pc = target;
          flush = 1'b1;
          push = 1'b1;
        end
        OPC_RETURN: begin
          if (exec_word.func == SUB_RETURN ||
              exec_word.func == SUB_INT_RETURN) begin
            next_pc = stack_top;
            pop = 1'b1;
            flush = 1'b1;
            set_int_enable = (exec_word.func == SUB_INT_RETURN);
          end
        end
        OPC_LOW_WR: begin
          next_pc = {pmem_addr_o[PC_W-1:8], exec_word.imm};
          flush = 1'b1;
        end
        default: ;
      endcase
    end
    // A full stack holds the request pending until a return frees a level.
    // Only a sequential boundary takes a request, so no branch is lost.
    if (!hold && !pop && !flush && int_req_i && int_enable &&
        !stack_full) begin
      take_int = 1'b1;
      next_pc = int_vector_i;
      push = 1'b1;
      push_data = pmem_addr_o;
      flush = 1'b1;
    end
    if (hold) begin
      next_pc = pmem_addr_o;
    end
  end

  // ==========================================================================
  // Program counter and execute stage
  // ==========================================================================
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pmem_addr_o <= RESET_VECTOR;
    end else if (boundary) begin
      pmem_addr_o <= next_pc;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      exec_word <= INSTR_RESET;
      dummy_cycle_o <= 1'b1;
      long_second <= 1'b0;
    end else if (boundary) begin
      long_second <= hold;
      if (!hold) begin
        exec_word <= fetch_word;
        dummy_cycle_o <= flush;
      end
    end
  end

  // ==========================================================================
  // Interrupt acknowledge
  // ==========================================================================
  // Acknowledge disables further requests until an interrupt return.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      int_ack_o <= 1'b0;
      int_enable <= INT_EN_RESET;
    end else if (ce_i) begin
      int_ack_o <= boundary && take_int;
      if (boundary && take_int) begin
        int_enable <= 1'b0;
      end else if (boundary && set_int_enable) begin
        int_enable <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Accumulator and status
  // ==========================================================================
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      acc_o <= ACC_RESET;
      status_o <= STATUS_RESET;
    end else if (boundary && exec_valid) begin
      if (write_acc) begin
        acc_o <= alu_out.result;
        status_o <= alu_out.status;
      end else if (exec_word.opc == OPC_LOW_RD) begin
        acc_o <= pmem_addr_o[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      stack_full_o <= 1'b0;
    end else if (ce_i) begin
      stack_full_o <= stack_full;
    end
  end

  // ==========================================================================
  // Submodules
  // ==========================================================================
  // The stack has no software port at all.
  pss_stack u_stack (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .push_i(boundary && push),
    .pop_i(boundary && pop),
    .data_i(push_data),
    .top_o(stack_top),
    .full_o(stack_full)
  );

  pss_alu u_alu (
    .a_i(acc_o),
    .b_i(exec_word.imm),
    .func_i(exec_word.func),
    .status_i(status_o),
    .out_o(alu_out)
  );

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  AST_PHASE_WRAP: assert property (
    boundary |=> phase_o == PH_FETCH ##1
    (phase_o == PH_DECODE || !$past(ce_i)))
    else $error("Phase did not wrap to fetch.");

  AST_PC_STEP: assert property (
    boundary && !flush && !hold
    |=> pmem_addr_o == $past(pmem_addr_o) + 13'h0001)
    else $error("Counter did not step by one.");

  AST_JUMP_FLUSH: assert property (
    boundary && exec_valid && exec_word.opc == OPC_JUMP
    |=> dummy_cycle_o && pmem_addr_o == $past(target))
    else $error("Jump did not flush and load target.");

  AST_SKIP_DUMMY: assert property (
    boundary && exec_valid && exec_word.opc == OPC_ALU && alu_out.skip
    |=> dummy_cycle_o && pmem_addr_o == $past(pmem_addr_o) + 13'h0001)
    else $error("Skip did not insert a dummy cycle.");

  AST_LOW_PAGE: assert property (
    boundary && exec_valid && exec_word.opc == OPC_LOW_WR && !take_int
    |=> dummy_cycle_o && pmem_addr_o[7:0] == $past(exec_word.imm)
        && pmem_addr_o[PC_W-1:8] == $past(pmem_addr_o[PC_W-1:8]))
    else $error("Low byte write left the page.");

  AST_RESET_VECTOR: assert property (
    disable iff (1'b0)
    srst_i |=> pmem_addr_o == RESET_VECTOR && dummy_cycle_o && !int_ack_o)
    else $error("Reset did not clear counter.");

  AST_INT_DEFER: assert property (
    boundary && stack_full |=> !int_ack_o)
    else $error("Interrupt acknowledged with full stack.");

  AST_LONG_TWO: assert property (
    boundary && exec_valid && exec_word.opc == OPC_LONG && !long_second
    |=> long_second && pmem_addr_o == $past(pmem_addr_o))
    else $error("Extended instruction did not take two cycles.");

  AST_ACK_VECTOR: assert property (
    boundary && take_int
    |=> int_ack_o && pmem_addr_o == $past(int_vector_i) && dummy_cycle_o)
    else $error("Acknowledge did not vector.");

  AST_CALL_FULL: assert property (
    boundary && exec_valid && exec_word.opc == OPC_CALL && stack_full
    |=> pmem_addr_o == $past(target) && stack_full)
    else $error("Call into full stack did not execute.");

  COV_CALL: cover property (boundary && exec_valid &&
                            exec_word.opc == OPC_CALL);
  COV_INT_DEFERRED: cover property (boundary && int_req_i && stack_full);
  COV_SKIP: cover property (boundary && exec_valid && alu_out.skip);
  COV_RETURN_THEN_ACK: cover property (boundary && pop ##[1:8] int_ack_o);

endmodule : pss_sequencer

// ---- test/pss_pmem_model.sv ----
// Behavioural program memory and interrupt request source.
`timescale 1ns/10ps
module pss_pmem_model import pss_pkg::*; #(
  parameter logic [PC_W-1:0] VECTOR = 13'h0800
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Program memory.
  input wire logic [PC_W-1:0] pmem_addr_i,
  output pss_instr_type pmem_data_o,
  // Interrupt source.
  input wire logic int_raise_i,
  input wire logic int_ack_i,
  output logic int_req_o,
  output logic [PC_W-1:0] int_vector_o
);
  // Unloaded words read as no-operation, so a stray fetch stays harmless.
  pss_instr_type rom [2**PC_W] = '{default: INSTR_RESET};

  // The word for the address answers within the same clock.
  assign pmem_data_o = rom[pmem_addr_i];

  // The request stays up until acknowledged, then drops.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || int_ack_i) begin
      int_req_o <= 1'b0;
    end else if (int_raise_i) begin
      int_req_o <= 1'b1;
    end
  end

  assign int_vector_o = VECTOR;
endmodule : pss_pmem_model

// ---- test/tb_top.sv ----
// Self-checking bench of the program sequencer with return stack.
`timescale 1ns/10ps
module tb_top import pss_pkg::*; ;
  // ==================
  // Tables
  typedef struct packed {
    pss_func_type func;
    logic [7:0] imm;
    logic [7:0] acc;
    logic [3:0] msk;
    logic [3:0] st;
  } pss_row_type;
  localparam logic [PC_W-1:0] VEC = 13'h0800;
  localparam logic [12:0] TR_DUMMY = 13'h1254;
  localparam logic [PC_W-1:0] TR_ADDR [13] = '{13'h0014, 13'h0015,
    13'h0016, 13'h0017, 13'h0100, 13'h0101, 13'h0140, 13'h0141, 13'h0142,
    13'h0017, 13'h0018, 13'h0019, 13'h03F0};
  // Status is only compared under the mask where its value is settled.
  localparam pss_row_type ROWS [19] = '{
    '{F_MOV,8'h5A,8'h5A,4'h0,4'h0}, '{F_AND,8'h0F,8'h0A,4'h4,4'h0},
    '{F_OR,8'h30,8'h3A,4'h0,4'h0}, '{F_XOR,8'hFF,8'hC5,4'h0,4'h0},
    '{F_CPL,8'h00,8'h3A,4'h0,4'h0}, '{F_ADD,8'hF0,8'h2A,4'hF,4'h1},
    '{F_ADC,8'h00,8'h2B,4'h1,4'h0}, '{F_SUB,8'h2B,8'h00,4'h5,4'h5},
    '{F_SBC,8'h01,8'hFF,4'h1,4'h0}, '{F_MOV,8'h81,8'h81,4'h0,4'h0},
    '{F_RLC,8'h00,8'h02,4'h1,4'h1}, '{F_RRC,8'h00,8'h81,4'h1,4'h0},
    '{F_RR,8'h00,8'hC0,4'h0,4'h0}, '{F_RL,8'h00,8'h81,4'h0,4'h0},
    '{F_INC,8'h00,8'h82,4'h4,4'h0}, '{F_DEC,8'h00,8'h81,4'h0,4'h0},
    '{F_MOV,8'h1A,8'h1A,4'h0,4'h0}, '{F_ADD,8'h00,8'h1A,4'h3,4'h0},
    '{F_DAA,8'h00,8'h20,4'h0,4'h0}};

  // ==================
  // Design and partner
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic int_raise = 1'b0;
  logic [PC_W-1:0] pmem_addr;
  pss_instr_type pmem_data;
  logic int_req;
  logic [PC_W-1:0] int_vector;
  logic int_ack;
  pss_phase_type phase;
  logic [DATA_W-1:0] acc;
  pss_status_type status;
  logic stack_full;
  logic dummy;
  int miscompares = 0;
  int checked = 0;
  int acks = 0;

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (int_ack === 1'b1) acks <= acks + 1;

  pss_sequencer uut (.ref_clk_i(ref_clk), .srst_i(srst), .ce_i(ce),
    .pmem_addr_o(pmem_addr), .pmem_data_i(pmem_data),
    .int_req_i(int_req), .int_vector_i(int_vector), .int_ack_o(int_ack),
    .phase_o(phase), .acc_o(acc), .status_o(status),
    .stack_full_o(stack_full), .dummy_cycle_o(dummy));

  pss_pmem_model #(.VECTOR(VEC)) mem (.ref_clk_i(ref_clk), .srst_i(srst),
    .pmem_addr_i(pmem_addr), .pmem_data_o(pmem_data),
    .int_raise_i(int_raise), .int_ack_i(int_ack), .int_req_o(int_req),
    .int_vector_o(int_vector));

  // ==================
  // Tasks
  task automatic conclude;
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic cmp_val(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  task automatic cmp_addr(input string what, input logic [PC_W-1:0] exp,
                          input logic [PC_W-1:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_addr

  task automatic put(input logic [PC_W-1:0] a, input logic [2:0] op,
                     input logic [12:0] arg);
    mem.rom[a] = {op, arg};
  endtask : put

  // Steps to the start of the next instruction cycle, counting clocks.
  task automatic next_fetch(output int edges);
    edges = 0;
    do begin
      @(posedge ref_clk);
      #1;
      edges++;
    end while (phase !== PH_FETCH && edges < 8);
    if (phase !== PH_FETCH) begin
      cmp_val("phase", 8'h01, {4'h0, phase});
      conclude();
    end
  endtask : next_fetch

  task automatic wait_addr(input logic [PC_W-1:0] a, input int limit);
    int n;
    for (int i = 0; i < limit && pmem_addr !== a; i++)
      next_fetch(n);
    cmp_addr("fetch address", a, pmem_addr);
  endtask : wait_addr

  // ==================
  // Sequence
  initial begin
    int n;
    foreach (ROWS[i])
      put(13'(i), 3'h0, {ROWS[i].func, ROWS[i].imm});
    put(13'h0013, 3'h5, {F_MOV, 8'h77});
    put(13'h0014, 3'h0, {F_SNZ, 8'h00});
    put(13'h0015, 3'h0, {F_MOV, 8'h11});
    put(13'h0016, 3'h2, 13'h0100);
    put(13'h0017, 3'h0, {F_SDZ, 8'h00});
    put(13'h0018, 3'h1, 13'h03F0);
    put(13'h0100, 3'h4, 13'h0040);
    put(13'h0140, 3'h6, 13'h0000);
    put(13'h0141, 3'h3, {SUB_RETURN, 8'h00});
    put(13'h03F0, 3'h2, 13'h0400);
    for (int k = 0; k < 7; k++) begin
      put(13'h0400 + 13'(k * 16), 3'h2, 13'h0410 + 13'(k * 16));
      put(13'h0401 + 13'(k * 16), 3'h3, {SUB_RETURN, 8'h00});
    end
    put(13'h0476, 3'h3, {SUB_RETURN, 8'h00});
    put(VEC, 3'h2, 13'h0900);
    put(VEC + 13'h0001, 3'h3, {SUB_INT_RETURN, 8'h00});
    put(13'h0900, 3'h3, {SUB_RETURN, 8'h00});
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    cmp_addr("fetch address", 13'h0000, pmem_addr);
    cmp_val("dummy", 8'h01, {7'h00, dummy});
    cmp_val("stack full", 8'h00, {7'h00, stack_full});
    cmp_val("accumulator", 8'h00, acc);
    for (int c = 1; c <= 20; c++) begin
      next_fetch(n);
      cmp_val("cycle length", 8'h04, 8'(n));
      cmp_addr("fetch address", 13'(c), pmem_addr);
      cmp_val("dummy", 8'h00, {7'h00, dummy});
      if (c >= 2) begin
        cmp_val("accumulator", ROWS[c-2].acc, acc);
        cmp_val("status", {4'h0, ROWS[c-2].st},
                {4'h0, status & ROWS[c-2].msk});
      end
    end
    for (int j = 0; j < 13; j++) begin
      next_fetch(n);
      cmp_addr("fetch address", TR_ADDR[j], pmem_addr);
      cmp_val("dummy", {7'h00, TR_DUMMY[j]}, {7'h00, dummy});
      if (j == 5)
        cmp_val("accumulator", 8'h77, acc);
      if (j == 9)
        cmp_val("accumulator", 8'h41, acc);
      if (j == 11)
        cmp_val("accumulator", 8'h40, acc);
    end
    // A low enable must freeze the phase and the counter mid-cycle.
    @(posedge ref_clk) ce <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    cmp_val("frozen phase", 8'h02, {4'h0, phase});
    cmp_addr("frozen address", 13'h03F0, pmem_addr);
    @(posedge ref_clk) ce <= 1'b1;
    wait_addr(13'h0460, 24);
    cmp_val("stack full", 8'h00, {7'h00, stack_full});
    wait_addr(13'h0470, 8);
    next_fetch(n);
    cmp_val("stack full", 8'h01, {7'h00, stack_full});
    @(posedge ref_clk) int_raise <= 1'b1;
    @(posedge ref_clk) int_raise <= 1'b0;
    wait_addr(13'h0476, 8);
    cmp_val("acknowledges", 8'h00, 8'(acks));
    wait_addr(VEC, 8);
    cmp_val("acknowledge", 8'h01, {7'h00, int_ack});
    @(posedge ref_clk);
    #1;
    cmp_val("acknowledge", 8'h00, {7'h00, int_ack});
    cmp_val("acknowledges", 8'h01, 8'(acks));
    wait_addr(13'h0900, 8);
    wait_addr(VEC + 13'h0001, 8);
    wait_addr(13'h0461, 8);
    wait_addr(13'h0401, 40);
    // The oldest entry was overwritten by the call made while full.
    wait_addr(VEC + 13'h0001, 8);
    @(posedge ref_clk) srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    cmp_addr("fetch address", 13'h0000, pmem_addr);
    cmp_val("stack full", 8'h00, {7'h00, stack_full});
    cmp_val("dummy", 8'h01, {7'h00, dummy});
    conclude();
  end
endmodule : tb_top
